// [pcg_top.sv]
// Programmable CRC generator: APB register file, data FIFO and 2-bit/cycle shift engine.
// Assumes one clock; sysIdle comes from logic on the same clock.
`timescale 1ns/1ps
module pcg_top
    import pcg_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic              clk_sys,
    input  wire logic              nrst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              sysIdle,
    output logic                   crcIrq
);

    // ****************************************************************
    // Helper functions
    // ****************************************************************
    function automatic logic [4:0] fifoDepth(input logic [4:0] dw);
        if (dw > WIDE_ABOVE) begin
            fifoDepth = DEPTH_WIDE;
        end else if (dw >= NARROW_BELOW) begin
            fifoDepth = DEPTH_MID;
        end else begin
            fifoDepth = DEPTH_NARROW;
        end
    endfunction : fifoDepth

    function automatic logic [31:0] lowMask(input logic [4:0] msb);
        lowMask = 32'hFFFFFFFF >> (5'h1F - msb);
    endfunction : lowMask

    function automatic logic [31:0] crcBit(input logic [31:0] crc, input logic din,
                                           input logic [31:0] poly, input logic [4:0] poly_length_field);
        logic fb;
        fb = din ^ crc[poly_length_field];
        crcBit = ((crc << 1) & lowMask(poly_length_field)) ^ (fb ? poly : 32'h00000000);
    endfunction : crcBit

    function automatic logic isMapped(input logic [ADDR_W-1:0] a);
        isMapped = (a == ADDR_W'(OFF_CTRL))    || (a == ADDR_W'(OFF_LENCFG)) ||
                   (a == ADDR_W'(OFF_TERMS_L)) || (a == ADDR_W'(OFF_TERMS_H)) ||
                   (a == ADDR_W'(OFF_DATA_L))  || (a == ADDR_W'(OFF_DATA_H)) ||
                   (a == ADDR_W'(OFF_RES_L))   || (a == ADDR_W'(OFF_RES_H));
    endfunction : isMapped

    // ****************************************************************
    // Declarations
    // ****************************************************************
    pcg_ctrl_t   ctrlQ;
    logic [4:0]  dwQ;
    logic [4:0]  plenQ;
    logic [31:0] termsQ;
    logic [15:0] datLoQ;
    logic [15:0] datHiQ;
    logic [31:0] resQ;
    logic [31:0] memQ [16];
    logic [3:0]  wrPtrQ;
    logic [3:0]  rdPtrQ;
    logic [4:0]  cntQ;
    logic [4:0]  cntD;
    logic [31:0] bufQ;
    logic [5:0]  bitsQ;
    logic [31:0] prdataQ;
    logic        preadyQ;
    logic        pslverrQ;
    logic        irqQ;
    logic        setupPh;
    logic        wrAcc;
    logic        wrCtl;
    logic        wrCfg;
    logic        wrTl;
    logic        wrTh;
    logic        wrDl;
    logic        wrDh;
    logic        wrRl;
    logic        wrRh;
    logic        fullNow;
    logic        emptyNow;
    logic        push;
    logic [31:0] pushWord;
    logic        run;
    logic        load;
    logic        step;
    logic        finish;
    logic        twoBits;
    logic [5:0]  idxA;
    logic [5:0]  idxB;
    logic [31:0] polyEff;
    logic [31:0] crcNext;
    logic [31:0] readMux;

    // ****************************************************************
    // APB slave
    // ****************************************************************
    assign setupPh = psel & ~penable;
    assign wrAcc   = psel & penable & preadyQ & pwrite;
    assign wrCtl   = wrAcc && (paddr == ADDR_W'(OFF_CTRL));
    assign wrCfg   = wrAcc && (paddr == ADDR_W'(OFF_LENCFG));
    assign wrTl    = wrAcc && (paddr == ADDR_W'(OFF_TERMS_L));
    assign wrTh    = wrAcc && (paddr == ADDR_W'(OFF_TERMS_H));
    assign wrDl    = wrAcc && (paddr == ADDR_W'(OFF_DATA_L));
    assign wrDh    = wrAcc && (paddr == ADDR_W'(OFF_DATA_H));
    assign wrRl    = wrAcc && (paddr == ADDR_W'(OFF_RES_L));
    assign wrRh    = wrAcc && (paddr == ADDR_W'(OFF_RES_H));

    always_comb begin
        readMux = 32'h00000000;
        unique case (paddr)
            ADDR_W'(OFF_CTRL): begin
                readMux[CTL_EN_BIT]                      = ctrlQ.en;
                readMux[CTL_SIDL_BIT]                    = ctrlQ.sidl;
                readMux[CTL_VW_LSB +: FIELD_W]           = cntQ;
                readMux[CTL_FULL_BIT]                    = fullNow;
                readMux[CTL_EMPTY_BIT]                   = emptyNow;
                readMux[CTL_ISEL_BIT]                    = ctrlQ.isel;
                readMux[CTL_GO_BIT]                      = ctrlQ.go;
                readMux[CTL_LEND_BIT]                    = ctrlQ.shift_direction_bit;
            end
            ADDR_W'(OFF_LENCFG): begin
                readMux[CFG_DW_LSB +: FIELD_W]           = dwQ;
                readMux[CFG_POLY_LENGTH_FIELD_LSB +: FIELD_W]         = plenQ;
            end
            ADDR_W'(OFF_TERMS_L): readMux[15:0]          = termsQ[15:0];
            ADDR_W'(OFF_TERMS_H): readMux[15:0]          = termsQ[31:16];
            ADDR_W'(OFF_DATA_L):  readMux[15:0]          = datLoQ;
            ADDR_W'(OFF_DATA_H):  readMux[15:0]          = datHiQ;
            ADDR_W'(OFF_RES_L):   readMux[15:0]          = resQ[15:0];
            ADDR_W'(OFF_RES_H):   readMux[15:0]          = resQ[31:16];
            default:              readMux                = 32'h00000000;
        endcase
    end

    // One wait-free access phase; answer is prepared during setup
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            preadyQ  <= 1'b0;
            pslverrQ <= 1'b0;
            prdataQ  <= 32'h00000000;
        end else begin
            preadyQ  <= setupPh;
            pslverrQ <= setupPh & ~isMapped(paddr);
            prdataQ  <= (setupPh & ~pwrite) ? readMux : 32'h00000000;
        end
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            dwQ    <= 5'h00;
            plenQ  <= 5'h00;
            termsQ <= 32'h00000000;
        end else begin
            if (wrCfg) begin
                dwQ   <= pwdata[CFG_DW_LSB +: FIELD_W];
                plenQ <= pwdata[CFG_POLY_LENGTH_FIELD_LSB +: FIELD_W];
            end
            if (wrTl) begin
                termsQ[15:0] <= {pwdata[15:1], 1'b0};
            end
            if (wrTh) begin
                termsQ[31:16] <= pwdata[15:0];
            end
        end
    end

    // Control bits; a software write of the start bit wins over a hardware clear
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrlQ <= '0;
        end else if (wrCtl) begin
            ctrlQ.en      <= pwdata[CTL_EN_BIT];
            ctrlQ.sidl    <= pwdata[CTL_SIDL_BIT];
            ctrlQ.isel    <= pwdata[CTL_ISEL_BIT];
            ctrlQ.go      <= pwdata[CTL_GO_BIT] & pwdata[CTL_EN_BIT];
            ctrlQ.shift_direction_bit <= pwdata[CTL_LEND_BIT];
        end else if (!ctrlQ.en || finish) begin
            ctrlQ.go <= 1'b0;
        end
    end

    // ****************************************************************
    // Input data pair and FIFO
    // ****************************************************************
    assign fullNow  = (cntQ >= fifoDepth(dwQ));
    assign emptyNow = (cntQ == 5'h00);
    // The word is complete when the half holding its MSb is written
    assign push     = ctrlQ.en && !fullNow &&
                      ((wrDl && (dwQ < HIGH_HALF_DW)) || (wrDh && (dwQ >= HIGH_HALF_DW)));
    assign pushWord = (wrDl ? {16'h0000, pwdata[15:0]} : {pwdata[15:0], datLoQ}) & lowMask(dwQ);

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            datLoQ <= 16'h0000;
            datHiQ <= 16'h0000;
        end else if (!ctrlQ.en) begin
            datLoQ <= 16'h0000;
            datHiQ <= 16'h0000;
        end else begin
            if (wrDl) begin
                datLoQ <= pwdata[15:0];
            end
            if (wrDh) begin
                datHiQ <= pwdata[15:0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            memQ[wrPtrQ] <= pushWord;
        end
    end

    always_comb begin
        cntD = cntQ + 5'(push) - 5'(load);
        if (!ctrlQ.en) begin
            cntD = 5'h00;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cntQ   <= 5'h00;
            wrPtrQ <= 4'h0;
            rdPtrQ <= 4'h0;
        end else begin
            cntQ <= cntD;
            if (!ctrlQ.en) begin
                wrPtrQ <= 4'h0;
                rdPtrQ <= 4'h0;
            end else begin
                wrPtrQ <= wrPtrQ + 4'(push);
                rdPtrQ <= rdPtrQ + 4'(load);
            end
        end
    end

    // ****************************************************************
    // Shift engine
    // ****************************************************************
    assign run     = ctrlQ.go && ctrlQ.en && !(ctrlQ.sidl && sysIdle);
    assign load    = run && (bitsQ == 6'h00) && (cntQ != 5'h00);
    assign step    = run && (bitsQ != 6'h00);
    assign finish  = run && (bitsQ == 6'h00) && (cntQ == 5'h00);
    assign twoBits = (bitsQ >= BITS_PER_CYC);
    assign polyEff = ({termsQ[31:1], 1'b1}) & lowMask(plenQ);

    always_comb begin
        if (ctrlQ.shift_direction_bit) begin
            idxA = {1'b0, dwQ} + 6'h01 - bitsQ;
            idxB = idxA + 6'h01;
        end else begin
            idxA = bitsQ - 6'h01;
            idxB = bitsQ - 6'h02;
        end
        crcNext = crcBit(resQ, bufQ[idxA[4:0]], polyEff, plenQ);
        if (twoBits) begin
            crcNext = crcBit(crcNext, bufQ[idxB[4:0]], polyEff, plenQ);
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            bufQ  <= 32'h00000000;
            bitsQ <= 6'h00;
        end else if (!ctrlQ.en) begin
            bufQ  <= 32'h00000000;
            bitsQ <= 6'h00;
        end else if (load) begin
            bufQ  <= memQ[rdPtrQ];
            bitsQ <= {1'b0, dwQ} + 6'h01;
        end else if (step) begin
            bitsQ <= bitsQ - (twoBits ? BITS_PER_CYC : 6'h01);
        end
    end

    // Result pair doubles as the remainder; software writes win
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            resQ <= 32'h00000000;
        end else if (!ctrlQ.en) begin
            resQ <= 32'h00000000;
        end else if (wrRl || wrRh) begin
            if (wrRl) begin
                resQ[15:0] <= pwdata[15:0];
            end
            if (wrRh) begin
                resQ[31:16] <= pwdata[15:0];
            end
        end else if (step) begin
            resQ <= crcNext & lowMask(plenQ);
        end
    end

    // ****************************************************************
    // Interrupt pulse
    // ****************************************************************
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            irqQ <= 1'b0;
        end else begin
            irqQ <= ctrlQ.en && ((!ctrlQ.isel && (cntQ == 5'h01) && (cntD == 5'h00)) ||
                                 (ctrlQ.isel && finish && !wrCtl));
        end
    end

    assign prdata  = prdataQ;
    assign pready  = preadyQ;
    assign pslverr = pslverrQ;
    assign crcIrq  = irqQ;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    sequence seqLoad;
        load ##1 (bitsQ == ($past(dwQ) + 5'h01));
    endsequence

    sequence seqFinish;
        finish && ctrlQ.isel && !wrCtl;
    endsequence

    chk_empty_flag:  assert property ((ctrlQ.en && cntQ == 5'h01 && load && !push) |=> emptyNow)
        else $error("empty flag wrong");
    chk_full_refuse: assert property ((fullNow && ctrlQ.en && wrDh && !load) |=> cntQ == $past(cntQ))
        else $error("push into full FIFO");
    chk_disable_clr: assert property (!ctrlQ.en |=> (cntQ == 5'h00) && (bitsQ == 6'h00) && (resQ == 32'h0))
        else $error("disable did not clear");
    chk_push_count:  assert property ((push && !load) |=> cntQ == $past(cntQ) + 5'h01)
        else $error("push not counted");
    chk_word_load:   assert property (load |-> seqLoad) else $error("word load wrong");
    chk_two_bits:    assert property ((step && twoBits && !wrCtl) |=> bitsQ == $past(bitsQ) - 6'h02)
        else $error("not two bits per cycle");
    chk_irq_words:   assert property ((ctrlQ.en && !ctrlQ.isel && cntQ == 5'h01 && load && !push) |=> crcIrq)
        else $error("count irq missing");
    chk_irq_done:    assert property (seqFinish |=> crcIrq && !ctrlQ.go) else $error("done irq missing");
    chk_idle_halt:   assert property ((ctrlQ.en && ctrlQ.sidl && sysIdle && !wrAcc) |=> $stable(resQ))
        else $error("engine ran in idle");
    chk_const_term:  assert property (wrTl |=> termsQ[0] == 1'b0) else $error("constant term bit stored");

endmodule : pcg_top

// [pcg_pkg.sv]
// Constants, field layout and types of the programmable CRC generator.
// Assumes an APB master with 32-bit data; each register is one aligned word.
package pcg_pkg;

    // ****************************************************************
    // Register byte offsets
    // ****************************************************************
    localparam logic [11:0] OFF_CTRL    = 12'h000;
    localparam logic [11:0] OFF_LENCFG  = 12'h004;
    localparam logic [11:0] OFF_TERMS_L = 12'h008;
    localparam logic [11:0] OFF_TERMS_H = 12'h00C;
    localparam logic [11:0] OFF_DATA_L  = 12'h010;
    localparam logic [11:0] OFF_DATA_H  = 12'h014;
    localparam logic [11:0] OFF_RES_L   = 12'h018;
    localparam logic [11:0] OFF_RES_H   = 12'h01C;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CTL_EN_BIT    = 15;
    localparam int CTL_SIDL_BIT  = 13;
    localparam int CTL_VW_LSB    = 8;
    localparam int CTL_FULL_BIT  = 7;
    localparam int CTL_EMPTY_BIT = 6;
    localparam int CTL_ISEL_BIT  = 5;
    localparam int CTL_GO_BIT    = 4;
    localparam int CTL_LEND_BIT  = 3;
    localparam int CFG_DW_LSB    = 8;
    localparam int CFG_POLY_LENGTH_FIELD_LSB  = 0;
    localparam int FIELD_W       = 5;

    // ****************************************************************
    // Depths, limits and reset values
    // ****************************************************************
    localparam logic [4:0] DEPTH_WIDE   = 5'h04;
    localparam logic [4:0] DEPTH_MID    = 5'h08;
    localparam logic [4:0] DEPTH_NARROW = 5'h10;
    localparam logic [4:0] WIDE_ABOVE   = 5'h0F;
    localparam logic [4:0] NARROW_BELOW = 5'h08;
    localparam logic [4:0] HIGH_HALF_DW = 5'h10;
    localparam logic       EMPTY_RST    = 1'b1;
    localparam logic [5:0] BITS_PER_CYC = 6'h02;

    typedef struct packed {
        logic en;
        logic sidl;
        logic isel;
        logic go;
        logic shift_direction_bit;
    } pcg_ctrl_t;

endpackage : pcg_pkg

// [programmable_crc_generator_tb_top.sv]
// Self-checking bench for the programmable CRC generator: APB master, result queue, reference CRC.
// Assumes pcg_top with pcg_pkg offsets and a wait-free registered APB answer.
`timescale 1ns/1ps
module programmable_crc_generator_tb_top
    import pcg_pkg::*;
;
    typedef struct packed {
        logic        chk;
        logic        err;
        logic [31:0] data;
    } pcg_exp_t;

    logic        clk_sys;
    logic        nrst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sysIdle;
    logic        crcIrq;
    int          err_count;
    int          num_checks;
    int          irqCount;
    int          cyc;
    time         t0;
    logic [31:0] lfsr;
    logic [31:0] rdVal;
    logic [31:0] crc;
    pcg_exp_t    expQ[$];

    pcg_top #(.ADDR_W(12)) dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sysIdle(sysIdle), .crcIrq(crcIrq));

    // ****************************************************************
    // Clock, checks, reference model
    // ****************************************************************
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task end_sim;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h0);
    endfunction : lfsr_next

    // Direct-form shift register, constant term always fed back, masked to length n
    function automatic logic [31:0] crc_ref(input logic [31:0] c, input logic [31:0] dat, input int w,
                                            input int n, input logic [31:0] poly, input logic lsb);
        logic [31:0] mask;
        logic        fb;
        mask = (n == 32) ? 32'hFFFFFFFF : ((32'h1 << n) - 32'h1);
        for (int i = 0; i < w; i++) begin
            fb = (lsb ? dat[i] : dat[w-1-i]) ^ c[n-1];
            c  = (c << 1) & mask;
            if (fb)
                c = c ^ ((poly | 32'h1) & mask);
        end
        return c;
    endfunction : crc_ref

    // ****************************************************************
    // APB master and answer monitor
    // ****************************************************************
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
             input logic chk, input logic [31:0] exp, input logic err);
        int n;
        expQ.push_back(pcg_exp_t'{chk, err, exp});
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_count++;
            end_sim();
        end
        rdVal = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b0, 32'h0, 1'b0);
    endtask : wr

    task rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 1'b1, exp, 1'b0);
    endtask : rd

    task poll_done;
        int n;
        n = 0;
        do begin
            apb(1'b0, OFF_CTRL, 32'h0, 1'b0, 32'h0, 1'b0);
            n++;
        end while (rdVal[CTL_GO_BIT] !== 1'b0 && n < 300);
        if (rdVal[CTL_GO_BIT] !== 1'b0) begin
            err_count++;
            end_sim();
        end
    endtask : poll_done

    always @(posedge clk_sys) begin : answer_mon
        pcg_exp_t e;
        if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
            if (expQ.size() == 0) begin
                err_count++;
                $display("FAIL %0t: answer without request", $time);
            end else begin
                e = expQ.pop_front();
                check({31'h0, pslverr}, {31'h0, e.err});
                if (e.chk)
                    check(prdata, e.data);
            end
        end
    end

    always @(posedge clk_sys)
        if (crcIrq === 1'b1)
            irqCount++;

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
        sysIdle = 1'b0; err_count = 0; num_checks = 0; irqCount = 0; lfsr = 32'h9E01;
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        rd(OFF_CTRL, 32'h40);
        rd(OFF_LENCFG, 32'h0);
        apb(1'b0, 12'h040, 32'h0, 1'b1, 32'h0, 1'b1);
        apb(1'b1, 12'h044, 32'hFFFF, 1'b0, 32'h0, 1'b1);
        $display("test reset values done");

        // Byte words, 16-bit polynomial, MSb first, halted in idle, seeded remainder
        wr(OFF_CTRL, 32'hA000);
        wr(OFF_LENCFG, 32'h070F);
        wr(OFF_TERMS_L, 32'h1021);
        rd(OFF_TERMS_L, 32'h1020);
        wr(OFF_TERMS_H, 32'hFFFF);
        lfsr = lfsr_next(lfsr);
        crc = {16'h0, lfsr[15:0]};
        wr(OFF_RES_L, crc);
        wr(OFF_RES_H, 32'h0);
        for (int i = 0; i < 17; i++) begin
            lfsr = lfsr_next(lfsr);
            wr(OFF_DATA_L, {16'h0, lfsr[15:0]});
            if (i < 16)
                crc = crc_ref(crc, {24'h0, lfsr[7:0]}, 8, 16, 32'hFFFF1021, 1'b0);
        end
        rd(OFF_CTRL, 32'hB080);
        sysIdle <= 1'b1;
        irqCount = 0;
        wr(OFF_CTRL, 32'hA010);
        repeat (40) @(posedge clk_sys);
        rd(OFF_CTRL, 32'hB090);
        sysIdle <= 1'b0;
        poll_done();
        rd(OFF_CTRL, 32'hA040);
        rd(OFF_RES_L, crc);
        rd(OFF_RES_H, 32'h0);
        check(32'(irqCount), 32'h1);
        $display("test byte stream done");

        // 25-bit words, 32-bit polynomial, LSb first, completion interrupt
        wr(OFF_CTRL, 32'h8028);
        wr(OFF_LENCFG, 32'h181F);
        wr(OFF_TERMS_H, 32'h04C1);
        wr(OFF_TERMS_L, 32'h1DB7);
        wr(OFF_RES_L, 32'h0);
        wr(OFF_RES_H, 32'h0);
        crc = 32'h0;
        for (int i = 0; i < 5; i++) begin
            lfsr = lfsr_next(lfsr);
            wr(OFF_DATA_L, {16'h0, lfsr[15:0]});
            if (i == 0)
                rd(OFF_CTRL, 32'h8068);
            wr(OFF_DATA_H, {16'h0, lfsr[31:16]});
            if (i < 4)
                crc = crc_ref(crc, lfsr & 32'h01FFFFFF, 25, 32, 32'h04C11DB7, 1'b1);
        end
        rd(OFF_CTRL, 32'h84A8);
        irqCount = 0;
        wr(OFF_CTRL, 32'h8038);
        t0 = $time;
        poll_done();
        cyc = int'(($time - t0) / 4);
        check({31'h0, cyc >= 52 && cyc <= 72}, 32'h1);
        rd(OFF_RES_L, {16'h0, crc[15:0]});
        rd(OFF_RES_H, {16'h0, crc[31:16]});
        check(32'(irqCount), 32'h1);
        sysIdle <= 1'b1;
        wr(OFF_CTRL, 32'hA028);
        wr(OFF_DATA_L, 32'h1234);
        wr(OFF_DATA_H, 32'h0001);
        wr(OFF_CTRL, 32'hA038);
        wr(OFF_CTRL, 32'hA028);
        sysIdle <= 1'b0;
        repeat (60) @(posedge clk_sys);
        check(32'(irqCount), 32'h1);
        wr(OFF_CTRL, 32'h0);
        rd(OFF_CTRL, 32'h40);
        rd(OFF_RES_L, 32'h0);
        rd(OFF_TERMS_H, 32'h04C1);
        rd(OFF_LENCFG, 32'h181F);
        $display("test wide words done");

        // 12-bit words: eight-deep FIFO
        wr(OFF_CTRL, 32'h8000);
        wr(OFF_LENCFG, 32'h0B0F);
        for (int i = 0; i < 9; i++) begin
            lfsr = lfsr_next(lfsr);
            wr(OFF_DATA_L, {16'h0, lfsr[15:0]});
        end
        rd(OFF_CTRL, 32'h8880);
        wr(OFF_CTRL, 32'h0);
        rd(OFF_CTRL, 32'h40);
        $display("test mid depth done");
        end_sim();
    end
endmodule : programmable_crc_generator_tb_top
